// >>> event_source.sv
// frame start and oscillator event sources seen by the timer
`timescale 1ns/1ps
module event_source (
  input wire logic clock, // system clock, paces the pulses
  output logic sof_pulse, // frame start event
  output logic low_freq_osc, // low frequency oscillator edge
  output logic ext_osc // external oscillator, runs free
);
  // ==========================================
  // free running external oscillator, unrelated in phase
  initial ext_osc = 1'b0;
  always #7 ext_osc = ~ext_osc;
  initial sof_pulse = 1'b0;
  initial low_freq_osc = 1'b0;
  // ==========================================
  // one rising edge on the chosen source, then a long low gap
  task automatic fire(input int which);
    @(posedge clock);
    if (which == 0)
      sof_pulse <= 1'b1;
    else
      low_freq_osc <= 1'b1;
    repeat (4) @(posedge clock);
    sof_pulse <= 1'b0;
    low_freq_osc <= 1'b0;
    // low gap longer than the synchroniser depth
    repeat (6) @(posedge clock);
  endtask
endmodule

// >>> event_sync.sv
// two flop synchroniser with rising edge detect for each event input
`timescale 1ns/1ps
module event_sync #(
  parameter int WIDTH = 3 // number of inputs
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // raw inputs from other domains
  output logic [WIDTH-1:0] rise // one cycle pulse per rising edge
);
  // refuse a width the generate loop cannot serve, at elaboration
  if (WIDTH < 1)
  begin : g_bad_width
    $error("event_sync width must be at least one");
  end
  // ==========================================
  // per input synchroniser
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_sync
      logic meta; // first stage, read only by stage two
      logic stable; // second stage
      logic last; // previous stable level
      // sample through two stages then remember level
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          meta <= 1'b0;
          stable <= 1'b0;
          last <= 1'b0;
        end
        else
        begin
          meta <= async_in[i];
          stable <= meta;
          last <= stable;
        end
      end
      assign rise[i] = stable & ~last; // edge from synchronised stages only
    end
  endgenerate
endmodule

// >>> timer_capture_split_control_tb_top.sv
// self-checking bench for the timer three capture and split control
`timescale 1ns/1ps
module timer_capture_split_control_tb_top;
  import timer_three_pkg::*;
  logic clock = 1'b0; // system clock
  logic rst = 1'b1; // synchronous reset
  sfr_req_t req = '0; // register access bundle
  logic irq_enable = 1'b1; // core interrupt enable
  logic high_sysclk_sel = 1'b1; // high byte on system clock
  logic low_sysclk_sel = 1'b1; // low byte on system clock
  logic sof_pulse; // frame start event
  logic low_freq_osc; // oscillator event
  logic ext_osc; // external oscillator
  logic [7:0] rd_data; // read data
  logic timer_irq; // interrupt request
  int n_errors = 0; // mismatch count
  int checks = 0; // comparison count
  int cycles = 0; // timeout counter
  int irq_seen = 0; // cycles with the request high
  int irq_base = 0; // request count at the start of a test
  // ==========================================
  // clock, timeout and request watcher
  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (timer_irq === 1'b1)
      irq_seen++;
    if (cycles == 20000)
    begin
      n_errors++;
      close_out();
    end
  end
  timer_three_capture uut (.clock(clock), .rst(rst), .req(req), .irq_enable(irq_enable),
    .high_sysclk_sel(high_sysclk_sel), .low_sysclk_sel(low_sysclk_sel),
    .sof_pulse(sof_pulse), .low_freq_osc(low_freq_osc), .ext_osc(ext_osc),
    .rd_data(rd_data), .timer_irq(timer_irq));
  event_source src (.clock(clock), .sof_pulse(sof_pulse), .low_freq_osc(low_freq_osc),
    .ext_osc(ext_osc));
  // ==========================================
  // bus tasks and comparison
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, write: 1'b1};
    @(posedge clock);
    req.write <= 1'b0;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    req.addr <= a;
    @(posedge clock);
    #1;
    check($sformatf("reg %h", a), exp, rd_data);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // reset values and an unmapped place
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_RELOAD_LOW, 8'h00);
    rd(ADDR_RELOAD_HIGH, 8'h00);
    rd(8'h90, 8'h00);
    $display("test reset done");
    // split capture, high byte held by a cleared run bit
    wr(ADDR_CONTROL, 8'h18);
    wr(ADDR_COUNT_HIGH, 8'h42);
    irq_base = irq_seen;
    src.fire(1);
    rd(ADDR_RELOAD_HIGH, 8'h00);
    check("irq unselected", 8'h00, 8'(irq_seen - irq_base));
    src.fire(0);
    rd(ADDR_RELOAD_HIGH, 8'h42);
    check("irq capture", 8'h01, 8'(irq_seen - irq_base));
    wr(ADDR_CONTROL, 8'h1A);
    wr(ADDR_COUNT_HIGH, 8'h37);
    irq_enable <= 1'b0;
    src.fire(1);
    rd(ADDR_RELOAD_HIGH, 8'h37);
    check("irq disabled", 8'h01, 8'(irq_seen - irq_base));
    @(posedge clock);
    irq_enable <= 1'b1;
    $display("test capture done");
    // low byte wraps alone, high byte untouched
    repeat (300) @(posedge clock);
    rd(ADDR_CONTROL, 8'h5A);
    rd(ADDR_COUNT_HIGH, 8'h37);
    check("irq low off", 8'h00, 8'(timer_irq));
    wr(ADDR_CONTROL, 8'h3A);
    repeat (300) @(posedge clock);
    #1;
    check("irq low on", 8'h01, 8'(timer_irq));
    @(posedge clock);
    low_sysclk_sel <= 1'b0;
    wr(ADDR_CONTROL, 8'h1A);
    rd(ADDR_CONTROL, 8'h1A);
    check("irq cleared", 8'h00, 8'(timer_irq));
    $display("test split done");
    // full sixteen bit wrap
    @(posedge clock);
    low_sysclk_sel <= 1'b1;
    wr(ADDR_CONTROL, 8'h04);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hF0);
    repeat (40) @(posedge clock);
    rd(ADDR_CONTROL, 8'hC4);
    check("irq full wrap", 8'h01, 8'(timer_irq));
    $display("test wide done");
    // slow clocks: low byte on external over eight, high byte on system over twelve
    @(posedge clock);
    high_sysclk_sel <= 1'b0;
    low_sysclk_sel <= 1'b0;
    wr(ADDR_CONTROL, 8'h0D);
    wr(ADDR_COUNT_LOW, 8'h00);
    // about 160 oscillator edges, so near twenty ticks
    repeat (448) @(posedge clock);
    #1;
    check("low ext ticks", 8'h01, 8'(rd_data >= 8'h12 && rd_data <= 8'h15));
    wr(ADDR_CONTROL, 8'h0C);
    wr(ADDR_COUNT_HIGH, 8'h00);
    // twenty prescaler periods of twelve
    repeat (240) @(posedge clock);
    #1;
    check("high slow ticks", 8'h01, 8'(rd_data >= 8'h12 && rd_data <= 8'h15));
    $display("test slow done");
    close_out();
  end
endmodule

// >>> timer_three_capture.sv
// timer three counter, split and capture control with its registers
//
// Contract
// - split bit makes two 8-bit counters
// - in split, each byte counts and wraps independently
// - capture copies both counter bytes to reloads
// - capture raises interrupt only when enabled
// - full wrap sets high flag, requests interrupt
// - low flag interrupts when low enable set
// - run bit gates high byte only in split
`timescale 1ns/1ps
module timer_three_capture
  import timer_three_pkg::*;
(
  input wire logic clock, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire timer_three_pkg::sfr_req_t req, // register access bundle
  input wire logic irq_enable, // timer interrupts enabled by core
  input wire logic high_sysclk_sel, // high byte runs on system clock
  input wire logic low_sysclk_sel, // low byte runs on system clock
  input wire logic sof_pulse, // frame start event pin
  input wire logic low_freq_osc, // low frequency oscillator pin
  input wire logic ext_osc, // external oscillator pin
  output logic [7:0] rd_data, // registered read data at req.addr
  output logic timer_irq // interrupt request level
);
  import timer_three_pkg::*;
  // ==========================================
  // state
  logic [7:0] control; // control register
  logic [7:0] counter_low_byte; // low counter
  logic [7:0] counter_high_byte; // high counter
  logic [7:0] reload_low_byte; // low reload or capture
  logic [7:0] reload_high_byte; // high reload or capture
  logic [3:0] prescale; // system clock divider
  logic [2:0] ext_count; // external clock divider
  logic [EVT_COUNT-1:0] rise; // synchronised event edges
  // ==========================================
  // event edges
  event_sync #(.WIDTH(EVT_COUNT)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({ext_osc, low_freq_osc, sof_pulse}),
    .rise(rise)
  );
  // ==========================================
  // decode of fields and ticks
  wire high_overflow_flag = control[BIT_HIGH_FLAG]; // high flag
  wire low_overflow_flag = control[BIT_LOW_FLAG]; // low flag
  wire low_byte_irq_enable = control[BIT_LOW_IRQ_EN]; // low irq enable
  wire capture_enable = control[BIT_CAPTURE_EN]; // capture mode
  wire split_select = control[BIT_SPLIT]; // split mode
  wire run_control = control[BIT_RUN]; // run bit
  wire capture_source_select = control[BIT_CAP_SOURCE]; // capture source
  wire ext_clock_select = control[BIT_EXT_CLOCK]; // external clock choice
  wire div12_tick = (prescale == SYS_DIVIDE - 4'h1); // system clock over twelve
  wire ext8_tick = rise[EVT_EXT_CLK] && (ext_count == EXT_DIVIDE); // external over eight
  wire slow_tick = ext_clock_select ? ext8_tick : div12_tick; // shared slow clock
  wire low_tick = low_sysclk_sel | slow_tick; // low byte clock
  wire high_tick = high_sysclk_sel | slow_tick; // high byte clock
  // in split mode low always runs, high follows run bit
  wire low_inc = split_select ? low_tick : (run_control & low_tick);
  wire low_wrap = low_inc && (counter_low_byte == BYTE_MAX);
  // split decouples the high byte from the low byte carry
  wire high_inc = split_select ? (run_control & high_tick) : low_wrap;
  wire high_wrap = high_inc && (counter_high_byte == BYTE_MAX);
  // source select picks the capture trigger
  wire cap_event = capture_source_select ? rise[EVT_LOW_OSC] : rise[EVT_SOF];
  wire capture = capture_enable & cap_event; // accepted capture
  wire reload_on_wrap = ~capture_enable; // auto reload outside capture
  wire wr_ctl = req.write && (req.addr == ADDR_CONTROL); // control write
  wire wr_rll = req.write && (req.addr == ADDR_RELOAD_LOW); // reload low write
  wire wr_rlh = req.write && (req.addr == ADDR_RELOAD_HIGH); // reload high write
  wire wr_cl = req.write && (req.addr == ADDR_COUNT_LOW); // counter low write
  wire wr_ch = req.write && (req.addr == ADDR_COUNT_HIGH); // counter high write
  // ==========================================
  // next values
  logic [7:0] next_control; // control with flag sets
  logic [7:0] next_low; // next low counter
  logic [7:0] next_high; // next high counter
  logic [7:0] next_rd; // read mux
  logic next_irq; // interrupt request
  // flags: software write, hardware set wins over clear
  always_comb
  begin
    next_control = wr_ctl ? req.wdata : control;
    if (low_wrap)
    begin
      next_control[BIT_LOW_FLAG] = 1'b1;
    end
    if (high_wrap)
    begin
      next_control[BIT_HIGH_FLAG] = 1'b1;
    end
  end
  // counters: software write first, then counting and reload
  always_comb
  begin
    next_low = counter_low_byte;
    next_high = counter_high_byte;
    if (wr_cl)
    begin
      next_low = req.wdata;
    end
    else if (low_wrap && reload_on_wrap && split_select)
    begin
      next_low = reload_low_byte; // split auto reload
    end
    else if (low_inc)
    begin
      next_low = counter_low_byte + 8'h01;
    end
    if (wr_ch)
    begin
      next_high = req.wdata;
    end
    else if (high_wrap && reload_on_wrap)
    begin
      next_high = reload_high_byte; // auto reload high
      if (!split_select && !wr_cl)
      begin
        next_low = reload_low_byte; // 16-bit reload
      end
    end
    else if (high_inc)
    begin
      next_high = counter_high_byte + 8'h01;
    end
  end
  // read selection
  always_comb
  begin
    case (req.addr)
      ADDR_CONTROL: next_rd = control;
      ADDR_RELOAD_LOW: next_rd = reload_low_byte;
      ADDR_RELOAD_HIGH: next_rd = reload_high_byte;
      ADDR_COUNT_LOW: next_rd = counter_low_byte;
      ADDR_COUNT_HIGH: next_rd = counter_high_byte;
      default: next_rd = 8'h00; // unmapped reads zero
    endcase
  end
  // flags and capture drive the request when enabled
  assign next_irq = irq_enable & (next_control[BIT_HIGH_FLAG]
                    | (next_control[BIT_LOW_FLAG] & next_control[BIT_LOW_IRQ_EN])
                    | capture);
  // ==========================================
  // registers and dividers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      control <= RESET_CONTROL;
      counter_low_byte <= RESET_BYTE;
      counter_high_byte <= RESET_BYTE;
      prescale <= 4'h0;
      ext_count <= 3'h0;
      timer_irq <= 1'b0;
      rd_data <= 8'h00;
    end
    else
    begin
      control <= next_control;
      counter_low_byte <= next_low;
      counter_high_byte <= next_high;
      prescale <= div12_tick ? 4'h0 : prescale + 4'h1;
      ext_count <= rise[EVT_EXT_CLK] ? ext_count + 3'h1 : ext_count;
      timer_irq <= next_irq;
      rd_data <= next_rd;
    end
  end
  // reload bytes: capture wins over a software write in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reload_low_byte <= RESET_BYTE;
      reload_high_byte <= RESET_BYTE;
    end
    else if (capture)
    begin
      reload_low_byte <= counter_low_byte;
      reload_high_byte <= counter_high_byte;
    end
    else
    begin
      reload_low_byte <= wr_rll ? req.wdata : reload_low_byte;
      reload_high_byte <= wr_rlh ? req.wdata : reload_high_byte;
    end
  end
  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_capture;
    capture && !$past(rst);
  endsequence
  chk_capture_copy: assert property (s_capture |=> reload_low_byte == $past(counter_low_byte)
    && reload_high_byte == $past(counter_high_byte))
    else $error("capture did not copy counters");
  chk_capture_same_cycle: assert property (capture |=> reload_high_byte
    == $past(counter_high_byte, 1))
    else $error("capture copy late");
  chk_capture_irq: assert property (capture && irq_enable |=> timer_irq)
    else $error("capture without interrupt");
  chk_no_irq_disabled: assert property (!irq_enable |=> !timer_irq)
    else $error("interrupt while disabled");
  chk_low_wrap_flag: assert property (low_wrap |=> low_overflow_flag)
    else $error("low wrap flag missing");
  chk_high_wrap_flag: assert property (high_wrap && irq_enable |=> high_overflow_flag
    && timer_irq)
    else $error("high wrap flag or request missing");
  chk_low_irq: assert property (low_overflow_flag && low_byte_irq_enable && irq_enable
    && !wr_ctl |=> timer_irq)
    else $error("low flag request missing");
  chk_split_high_hold: assert property (split_select && !run_control && !wr_ch
    && !wr_ctl |=> $stable(counter_high_byte))
    else $error("high byte ran while stopped");
  chk_split_low_runs: assert property (split_select && low_tick && !wr_cl && !wr_ctl
    && counter_low_byte != BYTE_MAX |=> counter_low_byte
    == $past(counter_low_byte) + 8'h01)
    else $error("split low byte did not count");
  chk_split_independent: assert property (split_select && low_wrap && !high_inc && !wr_ch
    && !wr_ctl |=> $stable(counter_high_byte))
    else $error("low wrap disturbed high byte");
  chk_source_select: assert property (capture_enable && capture_source_select
    && rise[EVT_SOF] && !rise[EVT_LOW_OSC] |-> !capture)
    else $error("wrong capture source");
  chk_flag_sticky: assert property (high_overflow_flag && !wr_ctl |=> high_overflow_flag)
    else $error("flag cleared by hardware");
endmodule

// >>> timer_three_pkg.sv
// shared constants and types for the timer three capture and split control
package timer_three_pkg;
  // ==========================================
  // special function register addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h91; // control and flags
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92; // reload or captured low byte
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93; // reload or captured high byte
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h94; // counter low byte
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95; // counter high byte
  // ==========================================
  // control register fields
  localparam int BIT_HIGH_FLAG = 7; // high overflow flag
  localparam int BIT_LOW_FLAG = 6; // low overflow flag
  localparam int BIT_LOW_IRQ_EN = 5; // low byte interrupt enable
  localparam int BIT_CAPTURE_EN = 4; // capture enable
  localparam int BIT_SPLIT = 3; // split select
  localparam int BIT_RUN = 2; // run control
  localparam int BIT_CAP_SOURCE = 1; // capture source select
  localparam int BIT_EXT_CLOCK = 0; // external clock select
  // ==========================================
  // reset values
  localparam logic [7:0] RESET_CONTROL = 8'h00; // control reset
  localparam logic [7:0] RESET_BYTE = 8'h00; // data byte reset
  localparam logic [7:0] BYTE_MAX = 8'hFF; // byte wrap point
  // ==========================================
  // timing counts
  localparam logic [3:0] SYS_DIVIDE = 4'hC; // system clock prescale
  localparam logic [2:0] EXT_DIVIDE = 3'h7; // external clock divide by eight, last count
  // event input indices
  localparam int EVT_SOF = 0; // start of frame pulse
  localparam int EVT_LOW_OSC = 1; // low frequency oscillator
  localparam int EVT_EXT_CLK = 2; // external oscillator
  localparam int EVT_COUNT = 3; // number of event inputs
  // ==========================================
  // register access request carried as one bundle
  typedef struct packed
  {
    logic [7:0] addr; // register address
    logic [7:0] wdata; // write data
    logic write; // write strobe, one cycle
  } sfr_req_t;
endpackage
